// *** rtl/acl_config_leadoff_regs.sv ***
// acl_config_leadoff_regs: second configuration, lead-off control and channel one settings
// registers behind an axi4-lite slave, with their fields decoded onto registered outputs.
// assumes one 10 MHz clock, a synchronous active-low reset and an asynchronous level on
// osc_internal_used from the clock-source strap.
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ns
module acl_config_leadoff_regs
  import acl_pkg::*;
#(
  parameter int ADDR_W      = 8,
  parameter int TEST_HALF   = TEST_HALF_CYCLES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        osc_internal_used,
  output logic             leadoff_comparator_power,
  output logic             reference_buffer_power,
  output logic             high_reference_select,
  output logic [12:0]      reference_millivolts,
  output logic             osc_clock_out_enable,
  output logic             test_signal_enable,
  output logic             test_waveform_select,
  output logic             test_signal_level,
  output logic [2:0]       comparator_threshold,
  output logic [9:0]       positive_threshold_permille,
  output logic [9:0]       negative_threshold_permille,
  output logic [1:0]       excitation_current_level,
  output logic [15:0]      excitation_nanoamps,
  output logic             detect_ac_select,
  output logic             channel_one_powerdown,
  output logic [2:0]       channel_one_gain,
  output logic [3:0]       channel_one_gain_value,
  output logic [INSEL_CODES-1:0] channel_one_input_onehot,
  output logic             channel_one_code_invalid
);

  // ------------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------------
  if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad_addr
    $error("ADDR_W must lie between 5 and 32");
  end
  if (TEST_HALF < 1 || TEST_HALF > 8388607) begin : g_bad_half
    $error("TEST_HALF must lie between 1 and 2**23-1");
  end

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  logic [7:0]        second_configuration_reg;
  logic [7:0]        lead_off_control_reg;
  logic [7:0]        channel_one_settings_reg;
  logic              aw_have_reg;
  logic              w_have_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0]       w_data_reg;
  logic [3:0]        w_strb_reg;
  logic              awready_reg;
  logic              wready_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              arready_reg;
  logic              rvalid_reg;
  logic [31:0]       rdata_reg;
  logic [1:0]        rresp_reg;
  logic              osc_meta_reg;
  logic              osc_sync_reg;
  logic [22:0]       test_count_reg;
  logic              test_phase_reg;
  logic [7:0]        out_cfg_reg;
  logic [7:0]        out_lead_off_control_reg;
  logic [7:0]        out_ch1_reg;
  logic              osc_out_reg;
  logic              test_level_reg;
  logic [12:0]       ref_mv_reg;
  logic [9:0]        pos_th_reg;
  logic [15:0]       exc_na_reg;
  logic [3:0]        gain_val_reg;
  logic [INSEL_CODES-1:0] insel_reg;
  logic              code_bad_reg;

  // ------------------------------------------------------------------
  // write path decode
  // ------------------------------------------------------------------
  // address and data may arrive in either order; a held half waits for the other
  wire              aw_hs       = awvalid & awready_reg;
  wire              w_hs        = wvalid & wready_reg;
  wire              aw_ok       = aw_have_reg | aw_hs;
  wire              w_ok        = w_have_reg | w_hs;
  wire              wr_fire     = aw_ok & w_ok & ~bvalid_reg;
  wire [ADDR_W-1:0] wr_addr     = aw_have_reg ? aw_addr_reg : awaddr;
  wire [31:0]       wr_data     = w_have_reg ? w_data_reg : wdata;
  wire [3:0]        wr_strb     = w_have_reg ? w_strb_reg : wstrb;
  wire [5:0]        wr_idx      = 6'(wr_addr[ADDR_W-1:2]);
  wire              wr_lane0    = wr_fire & wr_strb[0];
  wire              wr_cfg      = wr_lane0 & (wr_idx == SECOND_CONFIGURATION_IDX);
  wire              wr_lead_off_control     = wr_lane0 & (wr_idx == LEAD_OFF_CONTROL_IDX);
  wire              wr_ch1      = wr_lane0 & (wr_idx == CHANNEL_ONE_SETTINGS_IDX);
  wire              wr_mapped   = (wr_idx == SECOND_CONFIGURATION_IDX) |
                                  (wr_idx == LEAD_OFF_CONTROL_IDX) |
                                  (wr_idx == CHANNEL_ONE_SETTINGS_IDX) |
                                  (wr_idx == BLOCK_STATUS_IDX);

  // ------------------------------------------------------------------
  // read path decode
  // ------------------------------------------------------------------
  wire        ar_hs     = arvalid & arready_reg;
  wire [5:0]  rd_idx    = 6'(araddr[ADDR_W-1:2]);
  wire [7:0]  status_rd = {4'h0, code_bad_reg, osc_out_reg, test_phase_reg, osc_sync_reg};
  wire        rd_cfg    = rd_idx == SECOND_CONFIGURATION_IDX;
  wire        rd_lead_off_control   = rd_idx == LEAD_OFF_CONTROL_IDX;
  wire        rd_ch1    = rd_idx == CHANNEL_ONE_SETTINGS_IDX;
  wire        rd_stat   = rd_idx == BLOCK_STATUS_IDX;
  wire        rd_mapped = rd_cfg | rd_lead_off_control | rd_ch1 | rd_stat;
  // channel one word read back whole
  wire [7:0]  rd_byte   = rd_cfg  ? second_configuration_reg :
                          rd_lead_off_control ? lead_off_control_reg :
                          rd_ch1  ? channel_one_settings_reg :
                          rd_stat ? status_rd : 8'h00;

  // ------------------------------------------------------------------
  // field decode
  // ------------------------------------------------------------------
  // gain code to gain factor, reserved code gives 0
  function automatic logic [3:0] gain_of(input logic [2:0] code);
    case (code)
      3'b000:  gain_of = 4'd6;
      3'b001:  gain_of = 4'd1;
      3'b010:  gain_of = 4'd2;
      3'b011:  gain_of = 4'd3;
      3'b100:  gain_of = 4'd4;
      3'b101:  gain_of = 4'd8;
      3'b110:  gain_of = 4'd12;
      default: gain_of = 4'd0;
    endcase
  endfunction

  // threshold in tenths of a percent, positive side
  function automatic logic [9:0] pos_th_of(input logic [2:0] code);
    case (code)
      3'b000:  pos_th_of = 10'd950;
      3'b001:  pos_th_of = 10'd925;
      3'b010:  pos_th_of = 10'd900;
      3'b011:  pos_th_of = 10'd875;
      3'b100:  pos_th_of = 10'd850;
      3'b101:  pos_th_of = 10'd800;
      3'b110:  pos_th_of = 10'd750;
      default: pos_th_of = 10'd700;
    endcase
  endfunction

  function automatic logic [15:0] exc_of(input logic [1:0] code);
    case (code)
      2'b00:   exc_of = 16'd6;
      2'b01:   exc_of = 16'd22;
      2'b10:   exc_of = 16'd6000;
      default: exc_of = 16'd22000;
    endcase
  endfunction

  wire [2:0] th_code   = lead_off_control_reg[CMP_TH_LSB +: 3];
  wire [1:0] exc_code  = lead_off_control_reg[EXC_CUR_LSB +: 2];
  wire [2:0] gain_code = channel_one_settings_reg[CH1_GAIN_LSB +: 3];
  wire [3:0] insel     = channel_one_settings_reg[CH1_INSEL_LSB +: 4];
  wire       bad_code  = (gain_code == 3'b111) | (insel >= 4'(INSEL_CODES));

  // one line per defined input source
  logic [INSEL_CODES-1:0] insel_dec;
  for (genvar i = 0; i < INSEL_CODES; i++) begin : g_insel
    assign insel_dec[i] = (insel == 4'(i));
  end

  wire [12:0] ref_mv_next = second_configuration_reg[HIGH_REF_BIT] ? REF_HIGH_MV : REF_LOW_MV;
  // oscillator reaches the pin only when it is the clock in use
  wire        osc_out_next = second_configuration_reg[OSC_OUT_BIT] & osc_sync_reg;

  // test level: off gives 0, dc gives 1, square wave follows the phase
  wire test_on     = second_configuration_reg[TEST_ON_BIT];
  wire test_square = second_configuration_reg[TEST_WAVE_BIT];
  wire test_next   = test_on & (~test_square | test_phase_reg);
  wire half_done   = test_count_reg == 23'(TEST_HALF - 1);

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  // software writes land on the low byte lane only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      second_configuration_reg <= SECOND_CONFIGURATION_RST;
      lead_off_control_reg     <= LEAD_OFF_CONTROL_RST;
      channel_one_settings_reg <= CHANNEL_ONE_SETTINGS_RST;
    end else begin
      if (wr_cfg) second_configuration_reg <= wr_data[7:0];
      if (wr_lead_off_control) lead_off_control_reg <= wr_data[7:0];
      if (wr_ch1) channel_one_settings_reg <= wr_data[7:0];
    end
  end

  // write channel handshake, response after both halves are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      if (aw_hs) begin
        aw_addr_reg <= awaddr;
        awready_reg <= 1'b0;
      end else if (!aw_have_reg && !bvalid_reg) begin
        awready_reg <= 1'b1;
      end
      if (w_hs) begin
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
        wready_reg <= 1'b0;
      end else if (!w_have_reg && !bvalid_reg) begin
        wready_reg <= 1'b1;
      end
      aw_have_reg <= wr_fire ? 1'b0 : aw_ok;
      w_have_reg  <= wr_fire ? 1'b0 : w_ok;
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // read channel: one read in flight, address refused until the data is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= RESP_OKAY;
    end else if (ar_hs) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= {24'h00_0000, rd_byte};
      rresp_reg   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && rready) begin
      rvalid_reg  <= 1'b0;
      arready_reg <= 1'b1;
    end else if (!rvalid_reg) begin
      arready_reg <= 1'b1;
    end
  end

  // strap from the clock-source pin; only the second flop is read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_meta_reg <= 1'b0;
      osc_sync_reg <= 1'b0;
    end else begin
      osc_meta_reg <= osc_internal_used;
      osc_sync_reg <= osc_meta_reg;
    end
  end

  // half-period counter; held in reset while the square wave is not asked for
  // so each start begins with a full low half
  always_ff @(posedge aclk) begin
    if (!aresetn || !(test_on && test_square)) begin
      test_count_reg <= 23'h00_0000;
      test_phase_reg <= 1'b0;
    end else if (half_done) begin
      test_count_reg <= 23'h00_0000;
      test_phase_reg <= ~test_phase_reg;
    end else begin
      test_count_reg <= test_count_reg + 23'h00_0001;
    end
  end

  // output stage: every decoded output is one flop behind its register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_cfg_reg    <= SECOND_CONFIGURATION_RST;
      out_lead_off_control_reg   <= LEAD_OFF_CONTROL_RST;
      out_ch1_reg    <= CHANNEL_ONE_SETTINGS_RST;
      osc_out_reg    <= 1'b0;
      test_level_reg <= 1'b0;
      ref_mv_reg     <= REF_LOW_MV;
      pos_th_reg     <= 10'd950;
      exc_na_reg     <= 16'd6;
      gain_val_reg   <= 4'd6;
      insel_reg      <= INSEL_CODES'(1);
      code_bad_reg   <= 1'b0;
    end else begin
      out_cfg_reg    <= second_configuration_reg;
      out_lead_off_control_reg   <= lead_off_control_reg;
      out_ch1_reg    <= channel_one_settings_reg;
      osc_out_reg    <= osc_out_next;
      test_level_reg <= test_next;
      ref_mv_reg     <= ref_mv_next;
      pos_th_reg     <= pos_th_of(th_code);
      exc_na_reg     <= exc_of(exc_code);
      gain_val_reg   <= gain_of(gain_code);
      insel_reg      <= insel_dec;
      code_bad_reg   <= bad_code;
    end
  end

  // ------------------------------------------------------------------
  // port drive
  // ------------------------------------------------------------------
  assign awready = awready_reg;
  assign wready  = wready_reg;
  assign bvalid  = bvalid_reg;
  assign bresp   = bresp_reg;
  assign arready = arready_reg;
  assign rvalid  = rvalid_reg;
  assign rdata   = rdata_reg;
  assign rresp   = rresp_reg;

  assign leadoff_comparator_power    = out_cfg_reg[CMP_POWER_BIT];
  assign reference_buffer_power      = out_cfg_reg[REF_BUF_BIT];
  assign high_reference_select       = out_cfg_reg[HIGH_REF_BIT];
  assign reference_millivolts        = ref_mv_reg;
  assign osc_clock_out_enable        = osc_out_reg;
  assign test_signal_enable          = out_cfg_reg[TEST_ON_BIT];
  assign test_waveform_select        = out_cfg_reg[TEST_WAVE_BIT];
  assign test_signal_level           = test_level_reg;
  assign comparator_threshold        = out_lead_off_control_reg[CMP_TH_LSB +: 3];
  assign positive_threshold_permille = pos_th_reg;
  assign negative_threshold_permille = THRESHOLD_FULL - pos_th_reg;
  assign excitation_current_level    = out_lead_off_control_reg[EXC_CUR_LSB +: 2];
  assign excitation_nanoamps         = exc_na_reg;
  assign detect_ac_select            = out_lead_off_control_reg[DETECT_AC_BIT];
  assign channel_one_powerdown       = out_ch1_reg[CH1_PD_BIT];
  assign channel_one_gain            = out_ch1_reg[CH1_GAIN_LSB +: 3];
  assign channel_one_gain_value      = gain_val_reg;
  assign channel_one_input_onehot    = insel_reg;
  assign channel_one_code_invalid    = code_bad_reg;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_cfg_write;
    wr_cfg;
  endsequence
  sequence s_lead_off_control_write;
    wr_lead_off_control;
  endsequence

  a_comp_power_out: assert property (
    s_cfg_write |=> ##1 leadoff_comparator_power == $past(wr_data[CMP_POWER_BIT], 2))
    else $error("comparator power does not follow the written bit");
  a_ref_buffer_out: assert property (
    s_cfg_write |=> ##1 reference_buffer_power == $past(wr_data[REF_BUF_BIT], 2))
    else $error("reference buffer power does not follow the written bit");
  a_ref_level_map: assert property (
    reference_millivolts == (high_reference_select ? REF_HIGH_MV : REF_LOW_MV))
    else $error("reference level disagrees with its select");
  a_osc_out_gate: assert property (
    osc_clock_out_enable |-> $past(osc_sync_reg) && $past(second_configuration_reg[OSC_OUT_BIT]))
    else $error("oscillator driven out without enable or internal clock");
  a_test_off_low: assert property (
    !second_configuration_reg[TEST_ON_BIT] |=> !test_signal_level)
    else $error("test signal active while switched off");
  a_test_dc_high: assert property (
    (test_on && !test_square)[*2] |-> ##1 test_signal_level)
    else $error("dc test level not held high");
  a_threshold_pair: assert property (
    comparator_threshold == 3'b000 |-> positive_threshold_permille == 10'd950 &&
      negative_threshold_permille == 10'd50)
    else $error("default threshold pair wrong");
  a_excite_map: assert property (
    (s_lead_off_control_write and (wr_data[EXC_CUR_LSB +: 2] == 2'b10)) |=> ##1
      excitation_nanoamps == 16'd6000)
    else $error("excitation magnitude wrong for code 10");
  a_detect_mode: assert property (
    s_lead_off_control_write |=> ##1 detect_ac_select == $past(wr_data[DETECT_AC_BIT], 2))
    else $error("detect mode does not follow the written bit");
  a_ch1_readback: assert property (
    ar_hs && rd_ch1 |=> rvalid && rdata == {24'h00_0000, $past(channel_one_settings_reg)})
    else $error("channel one settings read back wrong");
  a_gain_map: assert property (
    channel_one_gain == 3'b101 |-> channel_one_gain_value == 4'd8)
    else $error("gain code 101 not mapped to 8");
  a_input_onehot: assert property (
    $onehot0(channel_one_input_onehot) &&
      ((channel_one_input_onehot == '0) ==
       ($past(channel_one_settings_reg[CH1_INSEL_LSB +: 4]) >= 4'(INSEL_CODES))))
    else $error("input select decode not one-hot");

endmodule

// *** rtl/acl_pkg.sv ***
// acl_pkg: shared constants for the front-end configuration register slice.
// assumes a 32-bit axi4-lite register port, a 10 MHz clock and byte addresses at four times
// the register index.
package acl_pkg;

  // ------------------------------------------------------------------
  // register indices and reset values
  // ------------------------------------------------------------------
  localparam logic [5:0] SECOND_CONFIGURATION_IDX = 6'h02;
  localparam logic [5:0] LEAD_OFF_CONTROL_IDX     = 6'h03;
  localparam logic [5:0] CHANNEL_ONE_SETTINGS_IDX = 6'h04;
  localparam logic [5:0] BLOCK_STATUS_IDX         = 6'h05;
  localparam logic [7:0] SECOND_CONFIGURATION_RST = 8'h80;
  localparam logic [7:0] LEAD_OFF_CONTROL_RST     = 8'h10;
  localparam logic [7:0] CHANNEL_ONE_SETTINGS_RST = 8'h00;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int CMP_POWER_BIT  = 6;  // second configuration
  localparam int REF_BUF_BIT    = 5;
  localparam int HIGH_REF_BIT   = 4;
  localparam int OSC_OUT_BIT    = 3;
  localparam int TEST_ON_BIT    = 1;
  localparam int TEST_WAVE_BIT  = 0;
  localparam int CMP_TH_LSB     = 5;  // lead-off control, three bits
  localparam int EXC_CUR_LSB    = 2;  // two bits
  localparam int DETECT_AC_BIT  = 0;
  localparam int CH1_PD_BIT     = 7;  // channel one settings
  localparam int CH1_GAIN_LSB   = 4;  // three bits
  localparam int CH1_INSEL_LSB  = 0;  // four bits
  localparam int INSEL_CODES    = 10; // codes 0000 to 1001 are defined

  // ------------------------------------------------------------------
  // analog values reported beside the codes
  // ------------------------------------------------------------------
  localparam logic [12:0] REF_LOW_MV       = 13'd2420;
  localparam logic [12:0] REF_HIGH_MV      = 13'd4033;
  localparam logic [11:0] TEST_AMPL_DIV    = 12'd2400;
  localparam logic [9:0]  THRESHOLD_FULL   = 10'd1000;
  localparam logic [2:0]  LEADOFF_AC_DIV   = 3'd4;

  // ------------------------------------------------------------------
  // timing: test square wave at 1 Hz
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS        = 100;
  localparam int TEST_HALF_PERIOD_NS  = 500_000_000;
  localparam int TEST_HALF_CYCLES     = TEST_HALF_PERIOD_NS / CLK_PERIOD_NS;

  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// *** verification/tb.sv ***
// tb: self-checking bench for the configuration and lead-off register slice.
// assumes the design answers on axi4-lite within a few cycles; the bench drives every port.
`timescale 1ns/1ns
module tb;
  import acl_pkg::*;
  // ------------------------------------------------------------------
  // signals and expectation tables
  // ------------------------------------------------------------------
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, osc_internal_used, osc_clock_out_enable;
  logic leadoff_comparator_power, reference_buffer_power, high_reference_select;
  logic test_signal_enable, test_waveform_select, test_signal_level, detect_ac_select;
  logic channel_one_powerdown, channel_one_code_invalid, prev;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb, channel_one_gain_value;
  logic [1:0] bresp, rresp, rsp, excitation_current_level;
  logic [12:0] reference_millivolts;
  logic [2:0] comparator_threshold, channel_one_gain;
  logic [9:0] positive_threshold_permille, negative_threshold_permille, channel_one_input_onehot;
  logic [15:0] excitation_nanoamps;
  int errors, check_count, cyc, n;
  logic [9:0] ptab [8] = '{10'h3B6, 10'h39D, 10'h384, 10'h36B, 10'h352, 10'h320, 10'h2EE, 10'h2BC};
  logic [3:0] gtab [8] = '{4'h6, 4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'hC, 4'h0};
  logic [15:0] etab [4] = '{16'h0006, 16'h0016, 16'h1770, 16'h55F0};
  // rows: written value, then {millivolts, test on, square, comparators, buffer, high ref}
  logic [25:0] rows [4] = '{{8'hD2, 13'hFC1, 5'h15}, {8'hA9, 13'h974, 5'h0A},
                           {8'hFB, 13'hFC1, 5'h1F}, {8'h80, 13'h974, 5'h00}};

  acl_config_leadoff_regs #(.ADDR_W(8), .TEST_HALF(8)) i_dut (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .osc_internal_used, .leadoff_comparator_power, .reference_buffer_power,
    .high_reference_select, .reference_millivolts, .osc_clock_out_enable, .test_signal_enable,
    .test_waveform_select, .test_signal_level, .comparator_threshold,
    .positive_threshold_permille, .negative_threshold_permille, .excitation_current_level,
    .excitation_nanoamps, .detect_ac_select, .channel_one_powerdown, .channel_one_gain,
    .channel_one_gain_value, .channel_one_input_onehot, .channel_one_code_invalid);

  // ------------------------------------------------------------------
  // bus tasks; values are read right after the edge, before its updates land
  // ------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // decoded outputs lag the write by two edges, so settle before looking
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    wr(a, d, 4'hF);
    chk("bresp", RESP_OKAY, rsp);
    repeat (3) @(posedge aclk);
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // clock, watchdog and main sequence
  // ------------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      summarize();
    end
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, osc_internal_used} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd_reg(8'h08);
    chk("rst_cfg2", 32'h80, rd);
    rd_reg(8'h0C);
    chk("rst_leadoff", 32'h10, rd);
    rd_reg(8'h10);
    chk("rst_ch1", 32'h00, rd);
    chk("rst_decode", {reference_millivolts, positive_threshold_permille, channel_one_gain_value,
        excitation_nanoamps}, {13'h974, 10'h3B6, 4'h6, 16'h0006});
    foreach (rows[i]) begin
      put(8'h08, rows[i][25:18]);
      chk("cfg2_fields", rows[i][17:0], {reference_millivolts, test_signal_enable,
          test_waveform_select, leadoff_comparator_power, reference_buffer_power,
          high_reference_select});
      rd_reg(8'h08);
      chk("cfg2_read", rows[i][25:18], rd);
    end
    for (int i = 0; i < 16; i++) begin
      put(8'h10, {i[0], i[2:0], i[3:0]});
      chk("ch1_pd", i[0], channel_one_powerdown);
      chk("ch1_gain", gtab[i[2:0]], channel_one_gain_value);
      chk("ch1_input", (i < 10) ? 32'h1 << i : 32'h0, channel_one_input_onehot);
      chk("ch1_bad", (i[2:0] == 3'h7) || (i >= 10), channel_one_code_invalid);
      if (i < 8) begin
        put(8'h0C, {i[2:0], 1'b1, i[1:0], 1'b0, i[0]});
        chk("thr_pos", ptab[i], positive_threshold_permille);
        chk("thr_neg", 32'h3E8 - ptab[i], negative_threshold_permille);
        chk("excite", etab[i[1:0]], excitation_nanoamps);
        chk("ac_sel", i[0], detect_ac_select);
        chk("thr_code", i[2:0], comparator_threshold);
        chk("exc_code", i[1:0], excitation_current_level);
        chk("ch1_gain_code", i[2:0], channel_one_gain);
      end
    end
    // awkward cases: unmapped place, empty strobe, oscillator gate, square wave
    wr(8'h20, 8'hFF, 4'hF);
    chk("unmapped_b", RESP_SLVERR, rsp);
    rd_reg(8'h20);
    chk("unmapped_r", 32'h0, rd);
    chk("unmapped_rresp", RESP_SLVERR, rsp);
    wr(8'h10, 8'h55, 4'h0);
    chk("no_strobe_b", RESP_OKAY, rsp);
    rd_reg(8'h10);
    chk("no_strobe", 32'hFF, rd);
    put(8'h08, 8'h88);
    chk("osc_gate_off", 1'b0, osc_clock_out_enable);
    osc_internal_used <= 1'b1;
    repeat (5) @(posedge aclk);
    chk("osc_gate_on", 1'b1, osc_clock_out_enable);
    rd_reg(8'h14);
    chk("status", 32'h0D, rd);
    chk("status_rresp", RESP_OKAY, rsp);
    put(8'h08, 8'h82);
    chk("test_dc", 1'b1, test_signal_level);
    put(8'h08, 8'h83);
    n = 0;
    prev = test_signal_level;
    repeat (32) begin
      @(posedge aclk);
      if (test_signal_level !== prev) n++;
      prev = test_signal_level;
    end
    chk("square_toggles", 32'h4, n);
    put(8'h08, 8'h80);
    chk("test_off", 2'b00, {test_signal_level, osc_clock_out_enable});
    summarize();
  end
endmodule
